// >>> smcr_pkg.sv
// Constants for the switch miscellaneous control register bank.
// Assumes an 8-bit management register port and a 40 MHz core clock.
`default_nettype none
package smcr_pkg;

	// Register offsets on the management port
	localparam logic [7:0] OFF_Q0_SPLIT     = 8'hBA;
	localparam logic [7:0] OFF_IRQ_ENABLE   = 8'hBB;
	localparam logic [7:0] OFF_LINK_STATUS  = 8'hBC;
	localparam logic [7:0] OFF_PAUSE_LIMIT  = 8'hBD;
	localparam logic [7:0] OFF_FIBER_THRESH = 8'hC0;
	localparam logic [7:0] OFF_REGULATOR    = 8'hC1;
	localparam logic [7:0] OFF_VLAN_INSERT  = 8'hC2;

	// Reset values of the stored fields
	localparam logic       RST_Q0_WEIGHTED  = 1'b1;
	localparam logic [7:0] RST_IRQ_ENABLE   = 8'h00;
	localparam logic [7:0] RST_LINK_STATUS  = 8'h00;
	localparam logic [7:0] RST_PAUSE_LIMIT  = 8'h00;
	localparam logic [1:0] RST_FIBER_THRESH = 2'h0;
	localparam logic       RST_REGULATOR    = 1'b0;
	localparam logic [5:0] RST_VLAN_INSERT  = 6'h00;

	// Read-only reserved field values
	localparam logic [6:0] RSV_Q0_SPLIT     = 7'h01;
	localparam logic [5:0] RSV_FIBER_THRESH = 6'h00;
	localparam logic [5:0] RSV_REGULATOR_LO = 6'h00;
	localparam logic       RSV_REGULATOR_HI = 1'b0;
	localparam logic [1:0] RSV_VLAN_INSERT  = 2'h0;
	localparam logic [7:0] READ_UNMAPPED    = 8'h00;

	// Field positions
	localparam int BIT_Q0_WEIGHTED = 7;
	localparam int BIT_LC_P1P2     = 7;
	localparam int BIT_LC_P3_MII   = 2;
	localparam int BIT_LC_P2_LINE  = 1;
	localparam int BIT_LC_P1_ANY   = 0;
	localparam int BIT_PAUSE_EN    = 0;
	localparam int BIT_FIBER_P2    = 7;
	localparam int BIT_FIBER_P1    = 6;
	localparam int BIT_REG_DISABLE = 6;
	localparam int BIT_P1_TO_P2    = 5;
	localparam int BIT_P1_TO_P3    = 4;
	localparam int BIT_P2_TO_P1    = 3;
	localparam int BIT_P2_TO_P3    = 2;
	localparam int BIT_P3_TO_P1    = 1;
	localparam int BIT_P3_TO_P2    = 0;

	// Writable / implemented status bits
	localparam logic [7:0] LINK_STATUS_MASK = 8'h87;

	// Pause time limit
	localparam int unsigned CLK_HZ             = 40000000;
	localparam int unsigned PAUSE_LIMIT_MS     = 160;
	localparam int unsigned PAUSE_LIMIT_CYCLES = PAUSE_LIMIT_MS * (CLK_HZ / 1000);
	localparam int          PAUSE_CNT_W        = 23;

endpackage : smcr_pkg
`default_nettype wire

// >>> smcr_pause_timer.sv
// Continuous-pause time limit counter for flow control.
// Assumes pause_active comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module smcr_pause_timer #(
	parameter int          CNT_W = smcr_pkg::PAUSE_CNT_W,
	parameter int unsigned LIMIT = smcr_pkg::PAUSE_LIMIT_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic pause_active,
	output var  logic expire
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             done_reg;
	logic             done_next;
	logic             expire_reg;
	logic             expire_next;
	wire  logic       running;
	wire  logic       at_limit;

	// Count only while limiting is on and pause is unbroken
	assign running  = enable && pause_active;
	assign at_limit = (cnt_reg == CNT_W'(LIMIT - 1));

	// One request per pause episode; done holds until pause ends
	assign cnt_next    = (!running) ? '0 : ((done_reg || at_limit) ? cnt_reg : cnt_reg + 1'b1);
	assign done_next   = running && (done_reg || at_limit);
	assign expire_next = running && !done_reg && at_limit;

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg    <= '0;
			done_reg   <= 1'b0;
			expire_reg <= 1'b0;
		end else begin
			cnt_reg    <= cnt_next;
			done_reg   <= done_next;
			expire_reg <= expire_next;
		end
	end

	assign expire = expire_reg;

endmodule : smcr_pause_timer
`default_nettype wire

// >>> smcr_regs.sv
// Miscellaneous control and status register bank of the switch core.
// Assumes link-change pulses and pause state come from same-clock logic.
// Function
// - Q0 split bit 7 picks strict priority (0) or weighted service (1).
// - Interrupt enable is an 8-bit read/write mask, reset 0x00.
// - Interrupt pin active while any enabled status bit is set.
// - Status bit 7 sets on port 1 or port 2 line change; W1C.
// - Status bit 2 sets on port 3 MII-side link change; W1C.
// - Status bit 1 sets on port 2 line-side link change; W1C.
// - Status bit 0 sets on port 1 line or MII change; W1C.
// - Enabled pause limit requests flow-control invalidation after 160 ms pause.
// - Bits 5,4 insert port 1 VLAN ID at egress ports 2,3.
// - Bits 3,2 insert port 2 VLAN ID at egress ports 1,3.
// - Bits 1,0 insert port 3 VLAN ID at egress ports 1,2; reset 0.
// - Regulator bit 6 high drives the regulator disable output; reset 0.
`timescale 1ns/100ps
`default_nettype none
module smcr_regs #(
	parameter int unsigned PAUSE_LIMIT_CYCLES = smcr_pkg::PAUSE_LIMIT_CYCLES
) (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_RD,
	output var  logic [7:0] REG_RDATA,
	input  wire logic       P1_LINK_CHG_LINE,
	input  wire logic       P1_LINK_CHG_MII,
	input  wire logic       P2_LINK_CHG_LINE,
	input  wire logic       P3_LINK_CHG_MII,
	input  wire logic       PAUSE_ACTIVE,
	output var  logic       LINK_IRQ_OUT_N,
	output var  logic       EGRESS_QUEUE_Q0_WEIGHTED,
	output var  logic       FLOW_CTRL_INVALIDATE,
	output var  logic       FIBER_P1_HIGH_THRESH,
	output var  logic       FIBER_P2_HIGH_THRESH,
	output var  logic       CORE_REGULATOR_DISABLE,
	output var  logic       INSERT_P1_VID_AT_P2,
	output var  logic       INSERT_P1_VID_AT_P3,
	output var  logic       INSERT_P2_VID_AT_P1,
	output var  logic       INSERT_P2_VID_AT_P3,
	output var  logic       INSERT_P3_VID_AT_P1,
	output var  logic       INSERT_P3_VID_AT_P2
);

	// Stored fields; reserved bits are not stored, except status bits 6:3 held in the flag register
	logic       q0_weighted_reg;
	logic       q0_weighted_next;
	logic [7:0] irq_enable_reg;
	logic [7:0] irq_enable_next;
	logic [7:0] link_change_flag_reg;
	logic [7:0] link_change_flag_next;
	logic [7:0] pause_limit_reg;
	logic [7:0] pause_limit_next;
	logic [1:0] fiber_reg;
	logic [1:0] fiber_next;
	logic       regulator_reg;
	logic       regulator_next;
	logic [5:0] vlan_insert_reg;
	logic [5:0] vlan_insert_next;
	logic       irq_n_reg;
	logic       irq_n_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// Write decode
	wire logic wr_q0;
	wire logic wr_ien;
	wire logic wr_stat;
	wire logic wr_pause;
	wire logic wr_fiber;
	wire logic wr_regu;
	wire logic wr_vlan;

	assign wr_q0    = REG_WR && (REG_ADDR == smcr_pkg::OFF_Q0_SPLIT);
	assign wr_ien   = REG_WR && (REG_ADDR == smcr_pkg::OFF_IRQ_ENABLE);
	assign wr_stat  = REG_WR && (REG_ADDR == smcr_pkg::OFF_LINK_STATUS);
	assign wr_pause = REG_WR && (REG_ADDR == smcr_pkg::OFF_PAUSE_LIMIT);
	assign wr_fiber = REG_WR && (REG_ADDR == smcr_pkg::OFF_FIBER_THRESH);
	assign wr_regu  = REG_WR && (REG_ADDR == smcr_pkg::OFF_REGULATOR);
	assign wr_vlan  = REG_WR && (REG_ADDR == smcr_pkg::OFF_VLAN_INSERT);

	// Link-change events mapped onto status bit positions
	wire logic [7:0] lc_set;
	wire logic [7:0] lc_clear;

	assign lc_set[smcr_pkg::BIT_LC_P1P2]    = P1_LINK_CHG_LINE || P2_LINK_CHG_LINE;
	assign lc_set[smcr_pkg::BIT_LC_P1P2-1:smcr_pkg::BIT_LC_P3_MII+1] = '0;
	assign lc_set[smcr_pkg::BIT_LC_P3_MII]  = P3_LINK_CHG_MII;
	assign lc_set[smcr_pkg::BIT_LC_P2_LINE] = P2_LINK_CHG_LINE;
	assign lc_set[smcr_pkg::BIT_LC_P1_ANY]  = P1_LINK_CHG_LINE || P1_LINK_CHG_MII;

	// Only ones in a status write clear; zeros leave flags alone
	assign lc_clear = wr_stat ? (REG_WDATA & smcr_pkg::LINK_STATUS_MASK) : 8'h00;

	// Next values; set is ORed last so a coincident event survives the clear
	assign q0_weighted_next      = wr_q0 ? REG_WDATA[smcr_pkg::BIT_Q0_WEIGHTED] : q0_weighted_reg;
	assign irq_enable_next       = wr_ien ? REG_WDATA : irq_enable_reg;
	assign link_change_flag_next = (link_change_flag_reg & ~lc_clear) | lc_set;
	assign pause_limit_next      = wr_pause ? REG_WDATA : pause_limit_reg;
	assign fiber_next            = wr_fiber ?
		{REG_WDATA[smcr_pkg::BIT_FIBER_P2], REG_WDATA[smcr_pkg::BIT_FIBER_P1]} : fiber_reg;
	assign regulator_next        = wr_regu ? REG_WDATA[smcr_pkg::BIT_REG_DISABLE] : regulator_reg;
	assign vlan_insert_next      = wr_vlan ?
		REG_WDATA[smcr_pkg::BIT_P1_TO_P2:smcr_pkg::BIT_P3_TO_P2] : vlan_insert_reg;

	// Interrupt pin is registered so it never glitches on the board
	assign irq_n_next = ~|(link_change_flag_next & irq_enable_next);

	// Read mux; reserved fields show their fixed defaults
	wire logic [7:0] rd_q0;
	wire logic [7:0] rd_fiber;
	wire logic [7:0] rd_regu;
	wire logic [7:0] rd_vlan;

	assign rd_q0    = {q0_weighted_reg, smcr_pkg::RSV_Q0_SPLIT};
	assign rd_fiber = {fiber_reg, smcr_pkg::RSV_FIBER_THRESH};
	assign rd_regu  = {smcr_pkg::RSV_REGULATOR_HI, regulator_reg, smcr_pkg::RSV_REGULATOR_LO};
	assign rd_vlan  = {smcr_pkg::RSV_VLAN_INSERT, vlan_insert_reg};

	assign rdata_next =
		!REG_RD ? rdata_reg :
		(REG_ADDR == smcr_pkg::OFF_Q0_SPLIT)     ? rd_q0 :
		(REG_ADDR == smcr_pkg::OFF_IRQ_ENABLE)   ? irq_enable_reg :
		(REG_ADDR == smcr_pkg::OFF_LINK_STATUS)  ? link_change_flag_reg :
		(REG_ADDR == smcr_pkg::OFF_PAUSE_LIMIT)  ? pause_limit_reg :
		(REG_ADDR == smcr_pkg::OFF_FIBER_THRESH) ? rd_fiber :
		(REG_ADDR == smcr_pkg::OFF_REGULATOR)    ? rd_regu :
		(REG_ADDR == smcr_pkg::OFF_VLAN_INSERT)  ? rd_vlan :
		smcr_pkg::READ_UNMAPPED;

	// Register update
	always_ff @(posedge CLK) begin
		if (RST) begin
			q0_weighted_reg      <= smcr_pkg::RST_Q0_WEIGHTED;
			irq_enable_reg       <= smcr_pkg::RST_IRQ_ENABLE;
			link_change_flag_reg <= smcr_pkg::RST_LINK_STATUS;
			pause_limit_reg      <= smcr_pkg::RST_PAUSE_LIMIT;
			fiber_reg            <= smcr_pkg::RST_FIBER_THRESH;
			regulator_reg        <= smcr_pkg::RST_REGULATOR;
			vlan_insert_reg      <= smcr_pkg::RST_VLAN_INSERT;
		end else begin
			q0_weighted_reg      <= q0_weighted_next;
			irq_enable_reg       <= irq_enable_next;
			link_change_flag_reg <= link_change_flag_next;
			pause_limit_reg      <= pause_limit_next;
			fiber_reg            <= fiber_next;
			regulator_reg        <= regulator_next;
			vlan_insert_reg      <= vlan_insert_next;
		end
	end

	// Pin and read-data registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_n_reg <= 1'b1;
			rdata_reg <= smcr_pkg::READ_UNMAPPED;
		end else begin
			irq_n_reg <= irq_n_next;
			rdata_reg <= rdata_next;
		end
	end

	// Pause limit uses only bit 0 as the enable; upper bits are stored
	smcr_pause_timer #(
		.CNT_W (smcr_pkg::PAUSE_CNT_W),
		.LIMIT (PAUSE_LIMIT_CYCLES)
	) u_pause_timer (
		.clk          (CLK),
		.rst          (RST),
		.enable       (pause_limit_reg[smcr_pkg::BIT_PAUSE_EN]),
		.pause_active (PAUSE_ACTIVE),
		.expire       (FLOW_CTRL_INVALIDATE)
	);

	// Outputs; sibling queue bits live elsewhere, scheduler combines them
	assign REG_RDATA                = rdata_reg;
	assign LINK_IRQ_OUT_N           = irq_n_reg;
	assign EGRESS_QUEUE_Q0_WEIGHTED = q0_weighted_reg;
	assign FIBER_P1_HIGH_THRESH     = fiber_reg[0];
	assign FIBER_P2_HIGH_THRESH     = fiber_reg[1];
	assign CORE_REGULATOR_DISABLE   = regulator_reg;
	assign INSERT_P1_VID_AT_P2      = vlan_insert_reg[smcr_pkg::BIT_P1_TO_P2];
	assign INSERT_P1_VID_AT_P3      = vlan_insert_reg[smcr_pkg::BIT_P1_TO_P3];
	assign INSERT_P2_VID_AT_P1      = vlan_insert_reg[smcr_pkg::BIT_P2_TO_P1];
	assign INSERT_P2_VID_AT_P3      = vlan_insert_reg[smcr_pkg::BIT_P2_TO_P3];
	assign INSERT_P3_VID_AT_P1      = vlan_insert_reg[smcr_pkg::BIT_P3_TO_P1];
	assign INSERT_P3_VID_AT_P2      = vlan_insert_reg[smcr_pkg::BIT_P3_TO_P2];

	// Checks on the scheduling bit and the interrupt mask
	AST_Q0_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_q0 |=> EGRESS_QUEUE_Q0_WEIGHTED == $past(REG_WDATA[smcr_pkg::BIT_Q0_WEIGHTED]))
		else $error("queue weighting bit not taken from write");

	AST_Q0_HOLD: assert property (@(posedge CLK) disable iff (RST)
		!wr_q0 |=> $stable(EGRESS_QUEUE_Q0_WEIGHTED))
		else $error("queue weighting bit changed without a write");

	// Reset is synchronous, so defaults show one edge after RST is seen
	AST_IEN_RESET: assert property (@(posedge CLK)
		RST |=> (irq_enable_reg == smcr_pkg::RST_IRQ_ENABLE &&
			EGRESS_QUEUE_Q0_WEIGHTED == smcr_pkg::RST_Q0_WEIGHTED))
		else $error("enable mask or weighting bit wrong after reset");

	AST_IEN_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_ien |=> irq_enable_reg == $past(REG_WDATA))
		else $error("enable mask not taken from write");

	// Pin register lines up with the flag and mask registers each cycle
	AST_IRQ_PIN: assert property (@(posedge CLK) disable iff (RST)
		LINK_IRQ_OUT_N == !(|(link_change_flag_reg & irq_enable_reg)))
		else $error("interrupt pin disagrees with enabled flags");

	AST_IRQ_MASKED: assert property (@(posedge CLK) disable iff (RST)
		(irq_enable_reg == 8'h00 && !wr_ien) |=> LINK_IRQ_OUT_N)
		else $error("interrupt pin active with empty mask");

	// Flags set by their events
	AST_LC_BIT7: assert property (@(posedge CLK) disable iff (RST)
		(P1_LINK_CHG_LINE || P2_LINK_CHG_LINE) |=> link_change_flag_reg[smcr_pkg::BIT_LC_P1P2])
		else $error("status bit 7 missed a link change");

	// Reserved status bits must never pick up an event
	AST_LC_BIT2: assert property (@(posedge CLK) disable iff (RST)
		P3_LINK_CHG_MII |=> link_change_flag_reg[smcr_pkg::BIT_LC_P3_MII] &&
			(link_change_flag_reg & ~smcr_pkg::LINK_STATUS_MASK) == 8'h00)
		else $error("status bit 2 missed a link change");

	AST_LC_BIT1: assert property (@(posedge CLK) disable iff (RST)
		P2_LINK_CHG_LINE |=> link_change_flag_reg[smcr_pkg::BIT_LC_P2_LINE] &&
			(!link_change_flag_reg[smcr_pkg::BIT_LC_P1_ANY] ||
			$past(link_change_flag_reg[smcr_pkg::BIT_LC_P1_ANY] || P1_LINK_CHG_LINE || P1_LINK_CHG_MII)))
		else $error("status bit 1 missed a link change");

	AST_LC_BIT0: assert property (@(posedge CLK) disable iff (RST)
		P1_LINK_CHG_MII |=> link_change_flag_reg[smcr_pkg::BIT_LC_P1_ANY])
		else $error("status bit 0 missed an MII link change");

	AST_LC_BIT0_LINE: assert property (@(posedge CLK) disable iff (RST)
		P1_LINK_CHG_LINE |=> link_change_flag_reg[smcr_pkg::BIT_LC_P1_ANY] &&
			link_change_flag_reg[smcr_pkg::BIT_LC_P1P2])
		else $error("status bits 0 and 7 missed a line link change");

	// Clearing semantics
	AST_W0_KEEPS: assert property (@(posedge CLK) disable iff (RST)
		(wr_stat && !REG_WDATA[smcr_pkg::BIT_LC_P1P2] && link_change_flag_reg[smcr_pkg::BIT_LC_P1P2])
		|=> link_change_flag_reg[smcr_pkg::BIT_LC_P1P2])
		else $error("writing zero cleared a flag");

	AST_W1_CLEARS: assert property (@(posedge CLK) disable iff (RST)
		(wr_stat && REG_WDATA[smcr_pkg::BIT_LC_P3_MII] && !P3_LINK_CHG_MII)
		|=> !link_change_flag_reg[smcr_pkg::BIT_LC_P3_MII])
		else $error("writing one did not clear a flag");

	AST_SET_WINS: assert property (@(posedge CLK) disable iff (RST)
		(wr_stat && REG_WDATA[smcr_pkg::BIT_LC_P2_LINE] && P2_LINK_CHG_LINE)
		|=> link_change_flag_reg[smcr_pkg::BIT_LC_P2_LINE])
		else $error("event lost to a coincident clear");

	// Without a write or an event the flags must not move
	AST_FLAG_HOLD: assert property (@(posedge CLK) disable iff (RST)
		(!wr_stat && !P1_LINK_CHG_LINE && !P1_LINK_CHG_MII && !P2_LINK_CHG_LINE &&
			!P3_LINK_CHG_MII) |=> $stable(link_change_flag_reg))
		else $error("status flags changed with no write or event");

	// Pause limit never requests while disabled
	AST_PAUSE_OFF: assert property (@(posedge CLK) disable iff (RST)
		!pause_limit_reg[smcr_pkg::BIT_PAUSE_EN] |=> !FLOW_CTRL_INVALIDATE)
		else $error("flow control invalidated with limit disabled");

	// One request per episode, so the pulse is never two cycles long
	AST_PAUSE_ONCE: assert property (@(posedge CLK) disable iff (RST)
		FLOW_CTRL_INVALIDATE |=> !FLOW_CTRL_INVALIDATE)
		else $error("flow control request longer than one cycle");

	AST_PAUSE_CAUSE: assert property (@(posedge CLK) disable iff (RST)
		FLOW_CTRL_INVALIDATE |-> $past(PAUSE_ACTIVE) &&
			$past(pause_limit_reg[smcr_pkg::BIT_PAUSE_EN]))
		else $error("flow control request without enabled pause");

	AST_PAUSE_NOPAUSE: assert property (@(posedge CLK) disable iff (RST)
		!PAUSE_ACTIVE |=> !FLOW_CTRL_INVALIDATE ##1 !FLOW_CTRL_INVALIDATE || PAUSE_ACTIVE)
		else $error("flow control invalidated without pause");

	// Insertion enables and regulator control follow writes
	AST_VLAN_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_vlan |=> ({INSERT_P1_VID_AT_P2, INSERT_P1_VID_AT_P3, INSERT_P2_VID_AT_P1,
			INSERT_P2_VID_AT_P3, INSERT_P3_VID_AT_P1, INSERT_P3_VID_AT_P2} ==
			$past(REG_WDATA[smcr_pkg::BIT_P1_TO_P2:smcr_pkg::BIT_P3_TO_P2])))
		else $error("insertion enables not taken from write");

	AST_VLAN_HOLD: assert property (@(posedge CLK) disable iff (RST)
		!wr_vlan |=> $stable(vlan_insert_reg))
		else $error("insertion enables changed without a write");

	AST_REGU_WRITE: assert property (@(posedge CLK) disable iff (RST)
		wr_regu |=> CORE_REGULATOR_DISABLE == $past(REG_WDATA[smcr_pkg::BIT_REG_DISABLE]))
		else $error("regulator disable not taken from write");

	AST_REGU_HOLD: assert property (@(posedge CLK) disable iff (RST)
		!wr_regu |=> $stable(CORE_REGULATOR_DISABLE))
		else $error("regulator disable changed without a write");

	// Reserved fields read back as defaults
	AST_RSV_READ: assert property (@(posedge CLK) disable iff (RST)
		(REG_RD && REG_ADDR == smcr_pkg::OFF_Q0_SPLIT) |=> REG_RDATA[6:0] == smcr_pkg::RSV_Q0_SPLIT)
		else $error("reserved field read wrong value");

	AST_RSV_VLAN: assert property (@(posedge CLK) disable iff (RST)
		(REG_RD && REG_ADDR == smcr_pkg::OFF_VLAN_INSERT) |=>
			REG_RDATA[7:6] == smcr_pkg::RSV_VLAN_INSERT)
		else $error("reserved insertion bits read nonzero");

endmodule : smcr_regs
`default_nettype wire

// >>> smcr_regs_tb.sv
// Self-checking testbench for the misc control register bank.
// Assumes smcr_regs and smcr_pkg are compiled first; pause limit shortened to 8.
`timescale 1ns/100ps
`default_nettype none
module smcr_regs_tb;
	localparam int LIM = 8;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [3:0] ev = 4'h0;
	logic       pause = 1'b0;
	wire  logic [7:0] rdata;
	wire  logic       irq_n;
	wire  logic       weighted;
	wire  logic       flow_inv;
	wire  logic       fib1;
	wire  logic       fib2;
	wire  logic       reg_dis;
	wire  logic [5:0] ins;
	int err_count = 0;
	int tests_run = 0;
	// Status each event input should set: P1 line, P1 MII, P2 line, P3 MII
	logic [7:0] exp_st [4] = '{8'h81, 8'h01, 8'h82, 8'h04};

	// Half period of 12.5 ns gives 40 MHz
	always #12.5 clk = ~clk;

	smcr_regs #(.PAUSE_LIMIT_CYCLES(LIM)) i_smcr_regs (
		.CLK                      (clk),
		.RST                      (rst),
		.REG_ADDR                 (addr),
		.REG_WR                   (wr_en),
		.REG_WDATA                (wdata),
		.REG_RD                   (rd_en),
		.REG_RDATA                (rdata),
		.P1_LINK_CHG_LINE         (ev[0]),
		.P1_LINK_CHG_MII          (ev[1]),
		.P2_LINK_CHG_LINE         (ev[2]),
		.P3_LINK_CHG_MII          (ev[3]),
		.PAUSE_ACTIVE             (pause),
		.LINK_IRQ_OUT_N           (irq_n),
		.EGRESS_QUEUE_Q0_WEIGHTED (weighted),
		.FLOW_CTRL_INVALIDATE     (flow_inv),
		.FIBER_P1_HIGH_THRESH     (fib1),
		.FIBER_P2_HIGH_THRESH     (fib2),
		.CORE_REGULATOR_DISABLE   (reg_dis),
		.INSERT_P1_VID_AT_P2      (ins[5]),
		.INSERT_P1_VID_AT_P3      (ins[4]),
		.INSERT_P2_VID_AT_P1      (ins[3]),
		.INSERT_P2_VID_AT_P3      (ins[2]),
		.INSERT_P3_VID_AT_P1      (ins[1]),
		.INSERT_P3_VID_AT_P2      (ins[0])
	);

	task automatic final_report;
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Write strobe held one full cycle; optional event pulse in the same cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e = 4'h0);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		ev = e;
		@(negedge clk);
		wr_en = 1'b0;
		ev = 4'h0;
	endtask : wr

	// Registered read data is looked at half a cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		chk(rdata, exp);
	endtask : rd

	task automatic t_reset_vals;
		rd(8'hBA, 8'h81);
		rd(8'hBB, 8'h00);
		rd(8'hBC, 8'h00);
		rd(8'hBD, 8'h00);
		rd(8'hC0, 8'h00);
		rd(8'hC1, 8'h00);
		rd(8'hC2, 8'h00);
		rd(8'hBE, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		chk({7'h00, weighted}, 8'h01);
		chk({2'h0, ins}, 8'h00);
		chk({5'h00, reg_dis, fib2, fib1}, 8'h00);
	endtask : t_reset_vals

	task automatic t_fields;
		wr(8'hBA, 8'h00);
		chk({7'h00, weighted}, 8'h00);
		rd(8'hBA, 8'h01);
		wr(8'hBA, 8'hFF);
		rd(8'hBA, 8'h81);
		chk({7'h00, weighted}, 8'h01);
		wr(8'hC1, 8'hFF);
		chk({7'h00, reg_dis}, 8'h01);
		rd(8'hC1, 8'h40);
		wr(8'hC1, 8'h00);
		chk({7'h00, reg_dis}, 8'h00);
		wr(8'hC0, 8'hFF);
		chk({6'h00, fib2, fib1}, 8'h03);
		rd(8'hC0, 8'hC0);
		wr(8'hC0, 8'h00);
		// One insertion enable at a time exposes swapped bits
		for (int i = 0; i < 6; i++) begin
			wr(8'hC2, 8'h01 << i);
			chk({2'h0, ins}, 8'h01 << i);
			rd(8'hC2, 8'h01 << i);
		end
		wr(8'hC2, 8'hFF);
		rd(8'hC2, 8'h3F);
		wr(8'hBB, 8'hA5);
		rd(8'hBB, 8'hA5);
		wr(8'hBE, 8'hFF);
		rd(8'hBE, 8'h00);
		wr(8'hBD, 8'hFE);
		rd(8'hBD, 8'hFE);
	endtask : t_fields

	task automatic t_link;
		wr(8'hBB, 8'h00);
		wr(8'hBC, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			wr(8'hBE, 8'h00, 4'h1 << i);
			rd(8'hBC, exp_st[i]);
			chk({7'h00, irq_n}, 8'h01);
			wr(8'hBC, 8'h00);
			rd(8'hBC, exp_st[i]);
			wr(8'hBB, exp_st[i]);
			chk({7'h00, irq_n}, 8'h00);
			wr(8'hBC, exp_st[i]);
			chk({7'h00, irq_n}, 8'h01);
			rd(8'hBC, 8'h00);
			wr(8'hBB, 8'h00);
		end
		// A clear that meets a fresh event must lose
		wr(8'hBB, 8'h02);
		wr(8'hBE, 8'h00, 4'h4);
		wr(8'hBC, 8'h02, 4'h4);
		rd(8'hBC, 8'h82);
		chk({7'h00, irq_n}, 8'h00);
		wr(8'hBC, 8'hFF);
		rd(8'hBC, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
	endtask : t_link

	// Counts cycles of continuous pause until the invalidate pulse
	task automatic measure_pause(input int upto, output int n);
		n = 0;
		while (n < upto && flow_inv !== 1'b1) begin
			@(negedge clk);
			n++;
		end
	endtask : measure_pause

	task automatic t_pause;
		int n;
		// Upper bits alone must not arm the limit
		wr(8'hBD, 8'hFE);
		pause = 1'b1;
		measure_pause(3 * LIM, n);
		chk(n[7:0], 8'(3 * LIM));
		pause = 1'b0;
		wr(8'hBD, 8'h01);
		pause = 1'b1;
		measure_pause(4 * LIM, n);
		if (n == 4 * LIM) begin
			err_count++;
			final_report();
		end
		chk(n[7:0], 8'(LIM));
		@(negedge clk);
		chk({7'h00, flow_inv}, 8'h00);
		measure_pause(2 * LIM, n);
		chk(n[7:0], 8'(2 * LIM));
		// A break in pause restarts the count
		pause = 1'b0;
		@(negedge clk);
		pause = 1'b1;
		repeat (LIM - 2) @(negedge clk);
		pause = 1'b0;
		@(negedge clk);
		pause = 1'b1;
		measure_pause(4 * LIM, n);
		chk(n[7:0], 8'(LIM));
		pause = 1'b0;
	endtask : t_pause

	task automatic t_rerun_reset;
		wr(8'hBB, 8'hFF);
		wr(8'hBE, 8'h00, 4'h8);
		chk({7'h00, irq_n}, 8'h00);
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk({7'h00, irq_n}, 8'h01);
		rd(8'hBC, 8'h00);
		rd(8'hBB, 8'h00);
		rd(8'hC2, 8'h00);
		rd(8'hBD, 8'h00);
	endtask : t_rerun_reset

	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_reset_vals();
		t_fields();
		t_link();
		t_pause();
		t_rerun_reset();
		final_report();
	end
endmodule : smcr_regs_tb
`default_nettype wire
